/* rtl/scp_pkg.sv */
// Overview of operation
// - Rising load strobe copies the whole staging buffer into active registers.
// - Hardware reset high returns registers and state to defaults, except the serial shift and instruction registers.
// - Abort input resets only the serial controller, asynchronously, active high.
// - Abort stops any transfer at once; host restarts after abort low.
// - Three-wire mode drives read data on the serial output pin.
// - Two-wire mode makes the data pin bidirectional; three-wire input only.
// - Select low addresses device; serial activity ignored while deselected.
// - Profile inputs sampled on sync clock, choosing one of four profiles.
// - Any profile change raises an internal load, like the strobe.
// - Keying direction sampled on sync clock; host holds it low unused.
// - Device drives its sync clock on an output pin.
// - Oscillator pin high enables oscillator; low bypasses it.
// - External power-down pin controls the power-down state.
package scp_pkg;
  // ==========================================================
  // Serial frame layout
  localparam int SCP_INSTR_W = 8;
  localparam int SCP_READ_BIT = 7;
  localparam int SCP_WORD_W = 32;
  localparam int SCP_NREG = 4;
  localparam int SCP_CNT_W = 6;
  // ==========================================================
  // Reset values and timing counts
  localparam logic [31:0] SCP_CTRL_RST = 32'h0000_0000;
  localparam int SCP_SYNC_DIV = 4;
  localparam int SCP_HW_RST_MIN_CYC = 5;
  // ==========================================================
  // Serial controller states
  typedef enum logic [1:0] {
    SCP_SP_INSTR,
    SCP_SP_DATA,
    SCP_SP_DONE
  } scp_sp_state_t;
endpackage

/* rtl/scp_control_pins.sv */
`timescale 1ns/1ns
`default_nettype none
module scp_control_pins
  import scp_pkg::*;
#(
  parameter int NREG = SCP_NREG,
  parameter int SYNC_DIV = SCP_SYNC_DIV
) (
  input wire logic i_core_clk, // 100 MHz core clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_hw_reset, // Hardware reset pin, high
  input wire logic i_load_strobe, // Update strobe pin
  input wire logic i_serial_port_abort, // Serial abort, high
  input wire logic i_cs_n, // Chip select, low
  input wire logic i_sclk, // Host serial clock
  input wire logic i_sdio_in, // Data pin level
  output logic o_sdio_out, // Data pin drive value
  output logic o_sdio_oe, // Data pin drive enable
  output logic o_serial_out_pin, // Read data, 3-wire
  input wire logic i_three_wire, // 1: 3-wire, 0: 2-wire
  input wire logic [1:0] i_profile_select, // Profile pins
  input wire logic i_keying_direction, // Keying ramp direction
  input wire logic i_sync_in, // Sync from another device
  output logic o_sync_clk, // Sync clock out
  input wire logic i_osc_enable_pin, // Oscillator mode pin
  input wire logic i_ext_powerdown_pin, // Power-down pin
  output logic o_osc_enable, // Oscillator enabled
  output logic o_powerdown, // Power-down request
  output logic [1:0] o_profile, // Sampled profile
  output logic o_keying_dir, // Sampled keying direction
  output logic o_load_pulse, // Buffer transfer event
  output logic [NREG-1:0][SCP_WORD_W-1:0] o_active // Active words
);
  localparam int AW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam int NS = 9;
  localparam int HALF = SYNC_DIV / 2;

  // ==========================================================
  // Pin synchronisers
  // Two flops on each of the nine pins below; stage two feeds a third for edges
  logic [NS-1:0] pin_in;
  logic [NS-1:0] s1_reg;
  logic [NS-1:0] s2_reg;
  logic [NS-1:0] s3_reg;
  assign pin_in = {i_hw_reset, i_load_strobe, i_cs_n, i_sclk,
                   i_sdio_in, i_sync_in, i_osc_enable_pin,
                   i_ext_powerdown_pin, i_keying_direction};
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  logic hw_rst;
  logic upd_rise;
  logic cs_n_s;
  logic sclk_rise;
  logic sdi_s;
  logic sync_in_rise;
  logic key_s;
  assign hw_rst = s2_reg[8];
  assign upd_rise = s2_reg[7] & ~s3_reg[7];
  assign cs_n_s = s2_reg[6];
  assign sclk_rise = s2_reg[5] & ~s3_reg[5];
  assign sdi_s = s2_reg[4];
  assign sync_in_rise = s2_reg[3] & ~s3_reg[3];
  assign key_s = s2_reg[0];

  // Profile pins, synchronised separately as a bus
  logic [1:0] ps1_reg;
  logic [1:0] ps2_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ps1_reg <= '0;
      ps2_reg <= '0;
    end else begin
      ps1_reg <= i_profile_select;
      ps2_reg <= ps1_reg;
    end
  end

  // Static mode pins pass straight through their synchronisers
  assign o_osc_enable = s2_reg[2];
  assign o_powerdown = s2_reg[1];

  // ==========================================================
  // Sync clock generator
  // Sync input edge restarts the divider to align devices
  logic [7:0] div_reg;
  logic sync_clk_reg;
  logic sync_evt;
  // Gated by restarts: a sample must never meet a divider being cleared
  assign sync_evt = ~hw_rst & ~sync_in_rise & (div_reg == 8'(HALF - 1)) & ~sync_clk_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
      sync_clk_reg <= 1'b0;
    end else if (hw_rst || sync_in_rise) begin
      div_reg <= '0;
      sync_clk_reg <= 1'b0;
    end else if (div_reg == 8'(HALF - 1)) begin
      div_reg <= '0;
      sync_clk_reg <= ~sync_clk_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end
  assign o_sync_clk = sync_clk_reg;

  // ==========================================================
  // Profile and keying sampling on sync clock rise
  logic [1:0] prof_reg;
  logic key_reg;
  logic prof_chg;
  assign prof_chg = sync_evt & (ps2_reg != prof_reg);
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prof_reg <= '0;
      key_reg <= 1'b0;
    end else if (hw_rst) begin
      prof_reg <= '0;
      key_reg <= 1'b0;
    end else if (sync_evt) begin
      prof_reg <= ps2_reg;
      key_reg <= key_s;
    end
  end
  assign o_profile = prof_reg;
  assign o_keying_dir = key_reg;

  // ==========================================================
  // Serial port controller
  // Abort resets this part alone, with no clock needed
  logic sp_rstn;
  assign sp_rstn = i_rstn & ~i_serial_port_abort;
  scp_sp_state_t sp_state;
  logic [SCP_CNT_W-1:0] bit_cnt;
  logic [SCP_INSTR_W-1:0] instr_reg;
  logic [SCP_WORD_W-1:0] wr_sh_reg;
  logic [SCP_WORD_W-1:0] rd_sh_reg;
  logic wr_done;
  logic [AW-1:0] wr_addr;
  logic wr_ok;
  logic [SCP_INSTR_W-1:0] instr_next;
  logic [NREG-1:0][SCP_WORD_W-1:0] active_reg;
  assign instr_next = {instr_reg[SCP_INSTR_W-2:0], sdi_s};
  assign wr_addr = AW'(instr_reg);
  // Full address compared, so high addresses never alias writes onto low words
  assign wr_ok = (32'(instr_reg[SCP_READ_BIT-1:0]) < NREG);

  // Frame sequencing; deselect parks the controller
  always_ff @(posedge i_core_clk or negedge sp_rstn) begin
    if (!sp_rstn) begin
      sp_state <= SCP_SP_INSTR;
      bit_cnt <= '0;
      instr_reg <= '0;
      wr_sh_reg <= '0;
      rd_sh_reg <= '0;
      wr_done <= 1'b0;
    end else if (hw_rst || cs_n_s) begin
      sp_state <= SCP_SP_INSTR;
      bit_cnt <= '0;
      wr_done <= 1'b0;
    end else begin
      wr_done <= 1'b0;
      if (sclk_rise) begin
        unique case (sp_state)
          SCP_SP_INSTR: begin
            instr_reg <= instr_next;
            if (bit_cnt == SCP_CNT_W'(SCP_INSTR_W - 1)) begin
              bit_cnt <= '0;
              sp_state <= SCP_SP_DATA;
              rd_sh_reg <= active_reg[AW'(instr_next)];
            end else begin
              bit_cnt <= bit_cnt + SCP_CNT_W'(1);
            end
          end
          SCP_SP_DATA: begin
            wr_sh_reg <= {wr_sh_reg[SCP_WORD_W-2:0], sdi_s};
            rd_sh_reg <= {rd_sh_reg[SCP_WORD_W-2:0], 1'b0};
            if (bit_cnt == SCP_CNT_W'(SCP_WORD_W - 1)) begin
              sp_state <= SCP_SP_DONE;
              wr_done <= ~instr_reg[SCP_READ_BIT];
            end else begin
              bit_cnt <= bit_cnt + SCP_CNT_W'(1);
            end
          end
          SCP_SP_DONE: begin
            bit_cnt <= '0;
          end
        endcase
      end
    end
  end

  // Read data drive; pin choice follows the port mode
  logic rd_active;
  assign rd_active = (sp_state == SCP_SP_DATA) & instr_reg[SCP_READ_BIT] & ~cs_n_s;
  assign o_serial_out_pin = i_three_wire & rd_active & rd_sh_reg[SCP_WORD_W-1];
  assign o_sdio_oe = ~i_three_wire & rd_active;
  assign o_sdio_out = o_sdio_oe & rd_sh_reg[SCP_WORD_W-1];

  // ==========================================================
  // Staging buffer and active registers
  // Writes land in staging only; the load moves all words
  logic [NREG-1:0][SCP_WORD_W-1:0] stage_reg;
  logic load_pulse;
  assign load_pulse = ~hw_rst & (upd_rise | prof_chg);
  assign o_load_pulse = load_pulse;
  assign o_active = active_reg;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage_reg <= {NREG{SCP_CTRL_RST}};
    end else if (hw_rst) begin
      stage_reg <= {NREG{SCP_CTRL_RST}};
    end else if (wr_done && wr_ok) begin
      stage_reg[wr_addr] <= wr_sh_reg;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      active_reg <= {NREG{SCP_CTRL_RST}};
    end else if (hw_rst) begin
      active_reg <= {NREG{SCP_CTRL_RST}};
    end else if (load_pulse) begin
      active_reg <= stage_reg;
    end
  end

  // ==========================================================
  // Checks
  property p_load_copy;
    @(posedge i_core_clk) disable iff (!i_rstn)
    load_pulse |=> (active_reg == $past(stage_reg));
  endproperty
  a_load_copy: assert property (p_load_copy) else $error("load did not copy staging");

  property p_hw_reset;
    @(posedge i_core_clk) disable iff (!i_rstn)
    hw_rst |=> (active_reg == {NREG{SCP_CTRL_RST}}) && (sp_state == SCP_SP_INSTR)
      && (prof_reg == 2'h0);
  endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("hardware reset left state");

  property p_abort_idle;
    @(posedge i_core_clk) disable iff (!i_rstn)
    i_serial_port_abort |-> (sp_state == SCP_SP_INSTR) && (bit_cnt == '0) && !wr_done;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort did not stop port");

  property p_sdo_mode;
    @(posedge i_core_clk) disable iff (!i_rstn)
    !i_three_wire |-> !o_serial_out_pin;
  endproperty
  a_sdo_mode: assert property (p_sdo_mode) else $error("serial out driven in 2-wire");

  property p_sdio_dir;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (i_three_wire || !rd_active) |-> !o_sdio_oe;
  endproperty
  a_sdio_dir: assert property (p_sdio_dir) else $error("data pin driven wrongly");

  property p_deselect;
    @(posedge i_core_clk) disable iff (!i_rstn || i_serial_port_abort)
    cs_n_s |=> (sp_state == SCP_SP_INSTR) && (bit_cnt == '0) && !wr_done;
  endproperty
  a_deselect: assert property (p_deselect) else $error("port active while deselected");

  property p_prof_load;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!$past(hw_rst) && $changed(prof_reg)) |-> (active_reg == $past(stage_reg));
  endproperty
  a_prof_load: assert property (p_prof_load) else $error("profile change without load");

  property p_active_hold;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!load_pulse && !hw_rst) |=> $stable(active_reg);
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active changed without load");

  property p_key_sample;
    @(posedge i_core_clk) disable iff (!i_rstn)
    (!sync_evt && !hw_rst) |=> $stable(key_reg) && $stable(prof_reg);
  endproperty
  a_key_sample: assert property (p_key_sample) else $error("sample off sync edge");

  property p_sync_toggle;
    @(posedge i_core_clk) disable iff (!i_rstn)
    sync_evt |=> $rose(sync_clk_reg);
  endproperty
  a_sync_toggle: assert property (p_sync_toggle) else $error("sync clock missed edge");

  // Main scenarios
  c_write: cover property (@(posedge i_core_clk) disable iff (!i_rstn) wr_done);
  c_read: cover property (@(posedge i_core_clk) disable iff (!i_rstn) rd_active ##1 !rd_active);
  c_prof: cover property (@(posedge i_core_clk) disable iff (!i_rstn) prof_chg);
  c_abort: cover property (@(posedge i_core_clk)
    (sp_state == SCP_SP_DATA) ##1 i_serial_port_abort);
endmodule
`default_nettype wire

/* tb/scp_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ====================
// Host side of the serial port
module scp_host_model (
  output logic o_cs_n, // Select, low
  output logic o_sclk, // Serial clock
  output logic o_sdio, // Write data
  input wire logic i_miso // Read data seen by host
);
  // Idle: deselected, clock standing still
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdio = 1'b0;
  end
  // One 40-bit frame MSB first; data moves on the low half of the clock
  task automatic frame(input logic sel, input logic [7:0] ins, input logic [31:0] wd,
                       output logic [31:0] rd);
    logic [39:0] sh;
    sh = {ins, wd};
    rd = '0;
    o_cs_n = ~sel;
    #80;
    for (int i = 39; i >= 0; i--) begin
      // Released in read phase: toggle so a stale level never matches
      o_sdio = (ins[7] && i < 32) ? ~o_sdio : sh[i];
      #80 o_sclk = 1'b1;
      if (i < 32) rd[i] = i_miso;
      #80 o_sclk = 1'b0;
    end
    o_cs_n = 1'b1;
    #80;
  endtask
endmodule
`default_nettype wire

/* tb/tb_synth_control_pin_interface.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_synth_control_pin_interface import scp_pkg::*; ();
  logic clk = 1'b0, rstn = 1'b0, hw_rst = 1'b0, ld = 1'b0, abort = 1'b0, three = 1'b1;
  logic [1:0] psel = 2'h0;
  logic kdir = 1'b0, osc = 1'b0, pdn = 1'b0, syn = 1'b0;
  wire logic cs_n, sclk, hsd;
  logic sd_out, sd_oe, so_pin, sync_clk, osc_en, pd, kd, lpulse, sd_wire, miso;
  logic [1:0] prof, prof_m;
  logic [SCP_NREG-1:0][SCP_WORD_W-1:0] act;
  logic [31:0] stg_m [SCP_NREG], act_m [SCP_NREG];
  int failures = 0, compares = 0, cyc = 0, nload = 0, nsync = 0;
  // ====================
  // Pin wiring: device drive wins the shared data line
  assign sd_wire = sd_oe ? sd_out : hsd;
  assign miso = three ? so_pin : sd_wire;
  always #5 clk = ~clk;
  scp_control_pins dut (.i_core_clk(clk), .i_rstn(rstn), .i_hw_reset(hw_rst),
    .i_load_strobe(ld), .i_serial_port_abort(abort), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_sdio_in(sd_wire), .o_sdio_out(sd_out), .o_sdio_oe(sd_oe),
    .o_serial_out_pin(so_pin), .i_three_wire(three), .i_profile_select(psel),
    .i_keying_direction(kdir), .i_sync_in(syn), .o_sync_clk(sync_clk),
    .i_osc_enable_pin(osc), .i_ext_powerdown_pin(pdn), .o_osc_enable(osc_en),
    .o_powerdown(pd), .o_profile(prof), .o_keying_dir(kd), .o_load_pulse(lpulse),
    .o_active(act));
  scp_host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_sdio(hsd), .i_miso(miso));
  // ====================
  // Event counters and hang guard
  always @(posedge sync_clk) nsync++;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (lpulse === 1'b1) nload <= nload + 1;
    if (cyc == 30000) begin
      failures++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_act();
    for (int i = 0; i < SCP_NREG; i++) check(act[i], act_m[i], "active word");
  endtask
  task automatic wr(input int a, input logic [31:0] d);
    logic [31:0] r;
    host.frame(1'b1, {1'b0, 7'(a)}, d, r);
    if (a < SCP_NREG) stg_m[a] = d;
  endtask
  task automatic rd_chk(input int a);
    logic [31:0] r;
    host.frame(1'b1, {1'b1, 7'(a)}, 32'h0, r);
    check(r, act_m[a], "read data");
  endtask
  // Strobe edge must give exactly one transfer
  task automatic load();
    int n;
    @(negedge clk) ld = 1'b1;
    n = nload;
    repeat (6) @(negedge clk);
    check(32'(nload - n), 32'h1, "load count");
    ld = 1'b0;
    act_m = stg_m;
    @(negedge clk);
    check_act();
  endtask
  // Pins change just after a sync clock rise, as the host must
  task automatic prof_set(input logic [1:0] p, input logic k);
    int n;
    @(posedge sync_clk);
    @(negedge clk);
    psel = p;
    kdir = k;
    n = nload;
    repeat (6 * SCP_SYNC_DIV) @(negedge clk);
    check(32'(prof), 32'(p), "profile");
    check(32'(kd), 32'(k), "keying");
    check(32'(nload - n), 32'(p != prof_m), "profile load");
    if (p != prof_m) act_m = stg_m;
    prof_m = p;
    check_act();
  endtask
  task automatic stop_test();
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ====================
  // Main sequence
  initial begin
    logic [31:0] r;
    int n;
    void'($urandom(32'h7e80));
    stg_m = '{default: '0};
    act_m = '{default: '0};
    prof_m = 2'h0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    check_act();
    n = nsync;
    repeat (40) @(negedge clk);
    check(32'(nsync - n), 32'(40 / SCP_SYNC_DIV), "sync rate");
    for (int a = 0; a <= SCP_NREG; a++) wr(a, $urandom());
    check_act();
    load();
    for (int a = SCP_NREG - 1; a >= 0; a--) rd_chk(a);
    three = 1'b0;
    for (int a = 0; a < SCP_NREG; a++) rd_chk(a);
    three = 1'b1;
    host.frame(1'b0, 8'h00, ~stg_m[0], r);
    load();
    // Abort lands mid-frame and stays up to its end
    fork
      host.frame(1'b1, 8'h01, ~stg_m[1], r);
      #(20 * 160) abort = 1'b1;
    join
    @(negedge clk) abort = 1'b0;
    repeat (4) @(negedge clk);
    check_act();
    wr(2, $urandom());
    load();
    for (int p = 1; p <= 4; p++) begin
      wr(p % SCP_NREG, $urandom());
      prof_set(2'(p), p[0]);
    end
    prof_set(2'h0, 1'b0);
    // Another device's sync edge, at a random phase, restarts our divider
    repeat (3) begin
      repeat ($urandom_range(3, 0)) @(negedge clk);
      syn = 1'b1;
      repeat (2 + SCP_SYNC_DIV / 2) @(negedge clk);
      check(32'(sync_clk), 32'h0, "sync restart");
      @(negedge clk);
      check(32'(sync_clk), 32'h1, "sync realign");
      syn = 1'b0;
      @(negedge clk);
    end
    repeat (4) begin
      @(negedge clk) {osc, pdn} = 2'($urandom());
      repeat (3) @(negedge clk);
      check(32'({osc_en, pd}), 32'({osc, pdn}), "mode pins");
    end
    wr(3, $urandom());
    @(negedge clk) hw_rst = 1'b1;
    repeat (5) @(negedge clk);
    hw_rst = 1'b0;
    stg_m = '{default: '0};
    act_m = '{default: '0};
    repeat (3) @(negedge clk);
    check_act();
    load();
    stop_test();
  end
endmodule
`default_nettype wire
